// [dbc_decode.sv]
// Purpose: Shared constants and the control-word field decoder of the descriptor block engine
// Assumes: One 16-bit block control word per descriptor, count halfword beside it
// Notes: Package first, decoder module after it in the same file
`default_nettype none
package dbc_pkg;
  localparam int CH_W = 2;
  localparam logic [31:0] ENTRY_STRIDE = 32'h0000_0010;
  localparam logic [31:0] OFS_CTRLWORD = 32'h0000_0000;
  localparam logic [31:0] OFS_BLKCNT = 32'h0000_0002;
  localparam logic [31:0] OFS_SRC = 32'h0000_0004;
  localparam logic [31:0] OFS_NEXT = 32'h0000_000C;
  localparam int CW_VALID = 0;
  localparam int CW_EVSEL_LO = 1;
  localparam int CW_ACT_LO = 3;
  localparam int CW_WIDTH_LO = 8;
  localparam int CW_SRCINC = 10;
  localparam int CW_CNT_LO = 16;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DESC_BASE = 8'h04;
  localparam logic [7:0] REG_WB_BASE = 8'h08;
  localparam logic [7:0] REG_INT_STAT = 8'h0C;
  localparam logic [7:0] REG_INT_MASK = 8'h10;
  localparam logic [7:0] REG_CH_STAT = 8'h14;
  localparam logic [7:0] REG_SRC_ADDR = 8'h18;
  localparam int CTL_START = 0;
  localparam int CTL_ABORT = 1;
  localparam int CTL_RESUME = 2;
  localparam int CTL_CH_LO = 4;
  localparam int INT_W = 4;
  localparam int INT_BLOCK = 0;
  localparam int INT_ERR = 1;
  localparam int INT_SUSP = 2;
  localparam int INT_DONE = 3;
  localparam logic [31:0] DESC_BASE_RST = 32'h0000_0000;
  localparam logic [31:0] WB_BASE_RST = 32'h0000_0000;
  localparam logic [INT_W-1:0] INT_MASK_RST = 4'h0;
  localparam logic [CH_W-1:0] CH_RST = 2'h0;
  typedef enum logic [1:0] {
    W_BYTE = 2'h0,
    W_HALF = 2'h1,
    W_WORD = 2'h2,
    W_RSVD = 2'h3
  } dbc_width_t;
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_INT = 2'h1,
    ACT_SUSP = 2'h2,
    ACT_BOTH = 2'h3
  } dbc_act_t;
  typedef enum logic [1:0] {
    EV_OFF = 2'h0,
    EV_BLOCK = 2'h1,
    EV_RSVD = 2'h2,
    EV_BEAT = 2'h3
  } dbc_ev_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FETCH = 3'h1,
    ST_BEAT = 3'h2,
    ST_WBACK = 3'h3,
    ST_SUSP = 3'h4
  } dbc_state_t;
  typedef enum logic [1:0] {
    END_DONE = 2'h0,
    END_ERR = 2'h1,
    END_ABORT = 2'h2
  } dbc_end_t;
endpackage
`default_nettype wire

`timescale 1ns/10ps
`default_nettype none
module dbc_decode import dbc_pkg::*; (
  input wire logic [15:0] ctrl_word,
  output logic valid,
  output logic src_inc,
  output dbc_width_t width,
  output logic width_bad,
  output logic [31:0] beat_bytes,
  output dbc_act_t act,
  output dbc_ev_t evsel
);
  assign valid = ctrl_word[CW_VALID];
  assign src_inc = ctrl_word[CW_SRCINC];
  assign width = dbc_width_t'(ctrl_word[CW_WIDTH_LO+:2]);
  assign width_bad = (width == W_RSVD);
  assign beat_bytes = (width == W_WORD) ? 32'h0000_0004 :
                      (width == W_HALF) ? 32'h0000_0002 : 32'h0000_0001;
  assign act = dbc_act_t'(ctrl_word[CW_ACT_LO+:2]);
  assign evsel = dbc_ev_t'(ctrl_word[CW_EVSEL_LO+:2]);
endmodule
`default_nettype wire

// [dbc_engine.sv]
// Purpose: Descriptor block engine for one active channel, with Wishbone registers
// Assumes: Memory and beat ports are on clk and answer with one-cycle acks
// Notes: Reserved width code ends the block as an error; reserved event code gives no event
`timescale 1ns/10ps
`default_nettype none
module dbc_engine import dbc_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  output logic beat_req,
  output logic [31:0] beat_addr,
  output logic [1:0] beat_size,
  input wire logic beat_ack,
  input wire logic beat_err,
  output logic evt_out,
  output logic irq
);
  logic wb_ack_r;
  logic [31:0] wb_dat_r_r;
  logic [31:0] desc_base_r;
  logic [31:0] wb_base_r;
  logic [INT_W-1:0] int_stat_r;
  logic [INT_W-1:0] int_mask_r;
  logic [CH_W-1:0] ch_r;
  dbc_state_t state_r, state_nxt;
  logic [1:0] fidx_r, fidx_nxt;
  logic [31:0] daddr_r, daddr_nxt;
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [31:0] src_r, src_nxt;
  logic [31:0] next_r, next_nxt;
  logic [31:0] maddr_r, maddr_nxt;
  logic [31:0] mwdata_r, mwdata_nxt;
  dbc_end_t endk_r, endk_nxt;
  logic evt_r, evt_nxt;
  logic [INT_W-1:0] int_set;

  // Bus decode
  wire wb_req = wb_cyc & wb_stb & ~wb_ack_r;
  wire wb_wr = wb_req & wb_we;
  wire hit_ctrl = (wb_adr == REG_CTRL);
  wire hit_dbase = (wb_adr == REG_DESC_BASE);
  wire hit_wbase = (wb_adr == REG_WB_BASE);
  wire hit_stat = (wb_adr == REG_INT_STAT);
  wire hit_mask = (wb_adr == REG_INT_MASK);
  wire hit_chst = (wb_adr == REG_CH_STAT);
  wire hit_src = (wb_adr == REG_SRC_ADDR);
  wire [31:0] wmask = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
  wire ctl_wr = wb_wr & hit_ctrl & wb_sel[0];
  wire start_p = ctl_wr & wb_dat_w[CTL_START];
  wire abort_p = ctl_wr & wb_dat_w[CTL_ABORT];
  wire resume_p = ctl_wr & wb_dat_w[CTL_RESUME];
  wire [INT_W-1:0] int_clr = (wb_wr & hit_stat & wb_sel[0]) ? wb_dat_w[INT_W-1:0] : '0;
  wire [31:0] rd_mux = hit_ctrl ? {26'h0, ch_r, 4'h0} :
                       hit_dbase ? desc_base_r :
                       hit_wbase ? wb_base_r :
                       hit_stat ? {28'h0, int_stat_r} :
                       hit_mask ? {28'h0, int_mask_r} :
                       hit_chst ? {cnt_r, 13'h0, state_r} :
                       hit_src ? src_r : 32'h0000_0000;

  // Entry addresses of the selected channel
  // Start may carry a new channel; the first fetch must already use it
  wire [CH_W-1:0] ch_sel = (ctl_wr && state_r == ST_IDLE) ? wb_dat_w[CTL_CH_LO+:CH_W] : ch_r;
  wire [31:0] chan_ofs = ENTRY_STRIDE * {30'h0, ch_sel};
  wire [31:0] tbl_entry = desc_base_r + chan_ofs;
  wire [31:0] wb_entry = wb_base_r + chan_ofs;
  wire [31:0] cnt_word_ofs = {OFS_BLKCNT[31:2], 2'h0};

  logic dec_valid, dec_inc, dec_wbad;
  dbc_width_t dec_width;
  logic [31:0] dec_bytes;
  dbc_act_t dec_act;
  dbc_ev_t dec_ev;

  dbc_decode u_dec (
    .ctrl_word(ctrl_r),
    .valid(dec_valid),
    .src_inc(dec_inc),
    .width(dec_width),
    .width_bad(dec_wbad),
    .beat_bytes(dec_bytes),
    .act(dec_act),
    .evsel(dec_ev)
  );

  wire last_blk = (next_r == 32'h0000_0000);
  wire [15:0] cw_cleared = ctrl_r & ~(16'h0001 << CW_VALID);

  always_comb begin
    state_nxt = state_r;
    fidx_nxt = fidx_r;
    daddr_nxt = daddr_r;
    ctrl_nxt = ctrl_r;
    cnt_nxt = cnt_r;
    src_nxt = src_r;
    next_nxt = next_r;
    maddr_nxt = maddr_r;
    mwdata_nxt = mwdata_r;
    endk_nxt = endk_r;
    evt_nxt = 1'b0;
    int_set = '0;
    case (state_r)
      ST_IDLE: begin
        if (start_p) begin
          state_nxt = ST_FETCH;
          fidx_nxt = 2'h0;
          daddr_nxt = tbl_entry;
          maddr_nxt = tbl_entry + cnt_word_ofs;
        end
      end
      ST_FETCH: begin
        if (abort_p) begin
          state_nxt = ST_WBACK;
          endk_nxt = END_ABORT;
        end else if (mem_ack) begin
          case (fidx_r)
            2'h0: begin
              ctrl_nxt = mem_rdata[15:0];
              cnt_nxt = mem_rdata[CW_CNT_LO+:16];
              if (!mem_rdata[CW_VALID]) begin
                state_nxt = ST_SUSP;
                int_set[INT_SUSP] = 1'b1;
              end else begin
                fidx_nxt = 2'h1;
                maddr_nxt = daddr_r + OFS_SRC;
              end
            end
            2'h1: begin
              src_nxt = mem_rdata;
              fidx_nxt = 2'h2;
              maddr_nxt = daddr_r + OFS_NEXT;
            end
            default: begin
              next_nxt = mem_rdata;
              state_nxt = ST_WBACK;
              if (dec_wbad) begin
                endk_nxt = END_ERR;
              end else if (cnt_r == 16'h0000) begin
                endk_nxt = END_DONE;
              end else begin
                state_nxt = ST_BEAT;
              end
            end
          endcase
        end
      end
      ST_BEAT: begin
        if (abort_p) begin
          state_nxt = ST_WBACK;
          endk_nxt = END_ABORT;
        end else if (beat_ack && beat_err) begin
          state_nxt = ST_WBACK;
          endk_nxt = END_ERR;
        end else if (beat_ack) begin
          cnt_nxt = cnt_r - 16'h0001;
          src_nxt = dec_inc ? src_r + dec_bytes : src_r;
          evt_nxt = (dec_ev == EV_BEAT);
          if (cnt_r == 16'h0001) begin
            state_nxt = ST_WBACK;
            endk_nxt = END_DONE;
          end
        end
      end
      ST_WBACK: begin
        if (mem_ack) begin
          state_nxt = ST_IDLE;
          if (endk_r == END_ERR) begin
            int_set[INT_ERR] = 1'b1;
          end else if (endk_r == END_DONE) begin
            evt_nxt = (dec_ev == EV_BLOCK);
            int_set[INT_BLOCK] = (dec_act == ACT_INT) || (dec_act == ACT_BOTH);
            daddr_nxt = next_r;
            if (dec_act == ACT_SUSP || dec_act == ACT_BOTH) begin
              state_nxt = ST_SUSP;
              int_set[INT_SUSP] = 1'b1;
            end else if (last_blk) begin
              int_set[INT_DONE] = 1'b1;
            end else begin
              state_nxt = ST_FETCH;
              fidx_nxt = 2'h0;
              maddr_nxt = next_r + cnt_word_ofs;
            end
          end
        end
      end
      ST_SUSP: begin
        if (abort_p) begin
          state_nxt = ST_IDLE;
        end else if (resume_p && daddr_r == 32'h0000_0000) begin
          state_nxt = ST_IDLE; // Suspended on the last block
          int_set[INT_DONE] = 1'b1;
        end else if (resume_p) begin
          state_nxt = ST_FETCH;
          fidx_nxt = 2'h0;
          maddr_nxt = daddr_r + cnt_word_ofs;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Entering write-back: valid cleared, remaining count kept for software
    if (state_nxt == ST_WBACK && state_r != ST_WBACK) begin
      maddr_nxt = wb_entry + cnt_word_ofs;
      mwdata_nxt = {cnt_nxt, cw_cleared};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      fidx_r <= 2'h0;
      daddr_r <= 32'h0000_0000;
      ctrl_r <= 16'h0000;
      cnt_r <= 16'h0000;
      src_r <= 32'h0000_0000;
      next_r <= 32'h0000_0000;
      maddr_r <= 32'h0000_0000;
      mwdata_r <= 32'h0000_0000;
      endk_r <= END_DONE;
      evt_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      fidx_r <= fidx_nxt;
      daddr_r <= daddr_nxt;
      ctrl_r <= ctrl_nxt;
      cnt_r <= cnt_nxt;
      src_r <= src_nxt;
      next_r <= next_nxt;
      maddr_r <= maddr_nxt;
      mwdata_r <= mwdata_nxt;
      endk_r <= endk_nxt;
      evt_r <= evt_nxt;
    end
  end

  // Register file; set beats clear so no event is lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_r <= 1'b0;
      wb_dat_r_r <= 32'h0000_0000;
      desc_base_r <= DESC_BASE_RST;
      wb_base_r <= WB_BASE_RST;
      int_stat_r <= '0;
      int_mask_r <= INT_MASK_RST;
      ch_r <= CH_RST;
    end else begin
      wb_ack_r <= wb_req;
      wb_dat_r_r <= (wb_req && !wb_we) ? rd_mux : 32'h0000_0000;
      int_stat_r <= (int_stat_r & ~int_clr) | int_set;
      if (wb_wr && hit_dbase) begin
        desc_base_r <= (desc_base_r & ~wmask) | (wb_dat_w & wmask);
      end
      if (wb_wr && hit_wbase) begin
        wb_base_r <= (wb_base_r & ~wmask) | (wb_dat_w & wmask);
      end
      if (wb_wr && hit_mask && wb_sel[0]) begin
        int_mask_r <= wb_dat_w[INT_W-1:0];
      end
      // Channel locked while a transfer owns the entry addresses
      if (ctl_wr && state_r == ST_IDLE) begin
        ch_r <= wb_dat_w[CTL_CH_LO+:CH_W];
      end
    end
  end

  assign wb_ack = wb_ack_r;
  assign wb_dat_r = wb_dat_r_r;
  assign mem_req = (state_r == ST_FETCH) || (state_r == ST_WBACK);
  assign mem_we = (state_r == ST_WBACK);
  assign mem_addr = maddr_r;
  assign mem_wdata = mwdata_r;
  assign beat_req = (state_r == ST_BEAT);
  assign beat_addr = src_r;
  assign beat_size = dec_width;
  assign evt_out = evt_r;
  assign irq = |(int_stat_r & int_mask_r);

  wire beat_ok = (state_r == ST_BEAT) && beat_ack && !beat_err && !abort_p;
  wire blk_end = (state_r == ST_WBACK) && mem_ack && (endk_r == END_DONE);

  a_src_fixed: assert property (@(posedge clk) disable iff (!rst_b)
    beat_ok && !dec_inc |=> src_r == $past(src_r)) else $error("source moved with increment off");
  a_src_step: assert property (@(posedge clk) disable iff (!rst_b)
    beat_ok && dec_inc |=> src_r == $past(src_r) + $past(dec_bytes)) else $error("source step wrong");
  a_beat_width: assert property (@(posedge clk) disable iff (!rst_b)
    beat_req |-> beat_size == ctrl_r[CW_WIDTH_LO+:2] && beat_size != 2'h3) else $error("beat width bad");
  a_last_disable: assert property (@(posedge clk) disable iff (!rst_b)
    blk_end && !dec_act[1] && last_blk |=> state_r == ST_IDLE && int_stat_r[INT_DONE] &&
    int_stat_r[INT_BLOCK] == $past(dec_act == ACT_INT)) else $error("last block not disabled");
  a_block_suspend: assert property (@(posedge clk) disable iff (!rst_b)
    blk_end && dec_act[1] |=> state_r == ST_SUSP && int_stat_r[INT_SUSP] &&
    int_stat_r[INT_BLOCK] == $past(dec_act[0])) else $error("block end suspend missing");
  a_event_beat: assert property (@(posedge clk) disable iff (!rst_b)
    beat_ok && dec_ev == EV_BEAT |=> evt_out) else $error("beat event missing");
  a_event_legal: assert property (@(posedge clk) disable iff (!rst_b)
    evt_out |-> ($past(dec_ev) == EV_BEAT && $past(beat_ok)) ||
    ($past(dec_ev) == EV_BLOCK && $past(blk_end)))
    else $error("event strobe without cause");
  a_block_event: assert property (@(posedge clk) disable iff (!rst_b)
    blk_end && dec_ev == EV_BLOCK |=> evt_out) else $error("block event missing");
  a_event_off: assert property (@(posedge clk) disable iff (!rst_b)
    dec_ev == EV_OFF |=> !evt_out) else $error("event with select off");
  a_susp_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == ST_SUSP |-> !mem_req && !beat_req) else $error("suspended channel still active");
  a_abort_wback: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == ST_FETCH || state_r == ST_BEAT) && abort_p |=> state_r == ST_WBACK &&
    !mem_wdata[CW_VALID]) else $error("abort did not clear valid");
  a_err_wback: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == ST_BEAT && beat_ack && beat_err && !abort_p |=> state_r == ST_WBACK &&
    mem_wdata[31:16] == $past(cnt_r)) else $error("error did not write back");
  a_stat_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    int_set != '0 |=> (int_stat_r & $past(int_set)) == $past(int_set))
    else $error("status set lost");
  a_ack_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    wb_ack |=> !wb_ack) else $error("bus ack longer than one cycle");
  a_invalid_susp: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == ST_FETCH && fidx_r == 2'h0 && mem_ack && !abort_p && !mem_rdata[CW_VALID]
    |=> state_r == ST_SUSP ##1 !beat_req) else $error("invalid descriptor not suspended");
  a_wb_clear: assert property (@(posedge clk) disable iff (!rst_b)
    mem_req && mem_we |-> !mem_wdata[CW_VALID] && mem_addr == wb_entry + cnt_word_ofs)
    else $error("write-back valid not cleared");
  a_fetch_addr: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == ST_IDLE && start_p |=> mem_addr == desc_base_r + {26'h0, ch_r, 4'h0})
    else $error("descriptor fetch address wrong");
endmodule
`default_nettype wire

// [dbc_mem_model.sv]
// Purpose: Memory and beat responder beside the descriptor engine
// Assumes: 64 words of store, byte address bits 7:2 pick the word
// Notes: Stall and bus error are set by the bench per scenario
`timescale 1ns/10ps
`default_nettype none
module dbc_mem_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  input wire logic beat_req,
  output logic beat_ack,
  output logic beat_err,
  input wire logic [1:0] stall,
  input wire logic err_on
);
  logic [31:0] mem [0:63];
  logic [1:0] mwait_r;
  logic [1:0] bwait_r;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      mwait_r <= 2'h0;
    end else if (mem_req && !mem_ack && mwait_r >= stall) begin
      mem_ack <= 1'b1;
      mwait_r <= 2'h0;
      mem_rdata <= mem[mem_addr[7:2]];
      if (mem_we) mem[mem_addr[7:2]] <= mem_wdata;
    end else begin
      mem_ack <= 1'b0;
      // Idle bus toggles so stale data never looks valid
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) mwait_r <= mwait_r + 2'h1;
    end
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      beat_ack <= 1'b0;
      beat_err <= 1'b0;
      bwait_r <= 2'h0;
    end else if (beat_req && !beat_ack && bwait_r >= stall) begin
      beat_ack <= 1'b1;
      beat_err <= err_on;
      bwait_r <= 2'h0;
    end else begin
      beat_ack <= 1'b0;
      beat_err <= 1'b0;
      if (beat_req && !beat_ack) bwait_r <= bwait_r + 2'h1;
    end
  end
endmodule
`default_nettype wire

// [tb_dma_descriptor_block_control.sv]
// Purpose: Self-checking bench for the descriptor block engine
// Assumes: Descriptor table at 0x40, write-back table at 0x80
// Notes: Width codes come from a seeded shift register, action and event codes from the loop index; reserved codes are never drawn
`timescale 1ns/10ps
`default_nettype none
module tb_dma_descriptor_block_control;
  import dbc_pkg::*;
  logic clk, rst_b, wb_cyc, wb_stb, wb_we, wb_ack, mem_req, mem_we, mem_ack;
  logic beat_req, beat_ack, beat_err, evt_out, irq, err_on;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, mem_addr, mem_wdata, mem_rdata, beat_addr, q, stat, src;
  logic [1:0] beat_size, stall;
  logic [31:0] beat_a[$];
  logic [1:0] beat_s[$];
  logic [15:0] rnd, ctrl;
  logic [2:0] st;
  int err_count, n_checks, evt_n;
  dbc_engine i_dbc_engine (.clk, .rst_b, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w,
    .wb_dat_r, .wb_ack, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
    .beat_req, .beat_addr, .beat_size, .beat_ack, .beat_err, .evt_out, .irq);
  dbc_mem_model i_dbc_mem_model (.clk, .rst_b, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack, .beat_req, .beat_ack, .beat_err, .stall, .err_on);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (beat_req && beat_ack) begin
      beat_a.push_back(beat_addr);
      beat_s.push_back(beat_size);
    end
    if (evt_out === 1'b1) evt_n++;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] exp_evt(input logic [1:0] e, input logic [15:0] n);
    exp_evt = (e == 2'h1) ? 32'h1 : (e == 2'h3) ? {16'h0, n} : 32'h0;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= d;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (wb_ack !== 1'b1 && t < 50);
    if (t >= 50) chk(t, 0);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic run(input logic [1:0] ch, input logic [15:0] n, input logic ab);
    int i;
    i_dbc_mem_model.mem[16+ch*4] = {n, ctrl};
    i_dbc_mem_model.mem[17+ch*4] = src;
    i_dbc_mem_model.mem[19+ch*4] = 32'h0;
    i_dbc_mem_model.mem[32+ch*4] = 32'hA5A5_0001;
    beat_a.delete();
    beat_s.delete();
    evt_n = 0;
    wb(1'b1, REG_CTRL, 32'h1 | (ch << CTL_CH_LO));
    if (ab) begin
      for (i = 0; i < 100 && beat_req !== 1'b1; i++) @(posedge clk);
      wb(1'b1, REG_CTRL, 32'h2 | (ch << CTL_CH_LO));
    end
    for (i = 0; i < 300; i++) begin
      wb(1'b0, REG_CH_STAT, 32'h0);
      st = q[2:0];
      if (st == 3'h0 || st == 3'h4) break;
    end
  endtask
  initial begin
    #(100 * 40000);
    chk(32'h0, 32'h1);
    summarize();
  end
  initial begin
    int k, i;
    logic [1:0] ch, act, ev, wd;
    logic inc;
    logic [15:0] n;
    rst_b = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h0;
    wb_sel = 4'hF;
    wb_dat_w = 32'h0;
    stall = 2'h0;
    err_on = 1'b0;
    err_count = 0;
    n_checks = 0;
    rnd = 16'h5;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    wb(1'b0, REG_DESC_BASE, 32'h0);
    chk(q, DESC_BASE_RST);
    wb(1'b0, REG_INT_MASK, 32'h0);
    chk(q, {28'h0, INT_MASK_RST});
    wb(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, REG_DESC_BASE, 32'h40);
    wb(1'b1, REG_WB_BASE, 32'h80);
    wb(1'b0, REG_WB_BASE, 32'h0);
    chk(q, 32'h80);
    for (k = 0; k < 24; k++) begin
      rnd = lfsr(rnd);
      act = k[1:0];
      ev = ((k / 4) % 3 == 0) ? 2'h0 : ((k / 4) % 3 == 1) ? 2'h1 : 2'h3;
      wd = rnd[1:0] % 2'h3;
      inc = rnd[2];
      n = 16'h1 + rnd[4:3];
      ch = rnd[6:5];
      stall <= rnd[8:7];
      src = 32'h1000 + {rnd[15:9], 2'h0};
      ctrl = {5'h0, inc, wd, 3'h0, act, ev, 1'b1};
      wb(1'b1, REG_INT_MASK, (k == 0) ? 32'h0 : 32'hF);
      run(ch, n, 1'b0);
      chk(beat_a.size(), n);
      for (i = 0; i < beat_a.size(); i++) begin
        chk(beat_a[i], src + (inc ? (i << wd) : 0));
        chk(beat_s[i], wd);
      end
      chk(evt_n, exp_evt(ev, n));
      wb(1'b0, REG_INT_STAT, 32'h0);
      stat = q;
      chk(stat[INT_BLOCK], act[0]);
      chk(st, act[1] ? 3'h4 : 3'h0);
      chk(irq, k != 0 && stat != 0);
      chk(i_dbc_mem_model.mem[32+ch*4], {16'h0, ctrl & 16'hFFFE});
      if (st == 3'h4) begin
        wb(1'b1, REG_CTRL, 32'h4 | (ch << CTL_CH_LO));
        wb(1'b0, REG_INT_STAT, 32'h0);
        chk(q[INT_DONE], 1'b1);
      end
      wb(1'b1, REG_INT_STAT, 32'hF);
      wb(1'b0, REG_INT_STAT, 32'h0);
      chk(q, 32'h0);
      chk(irq, 1'b0);
    end
    ctrl = 16'h0002;
    run(2'h1, 16'h2, 1'b0);
    chk(st, 3'h4);
    chk(beat_a.size(), 0);
    chk(i_dbc_mem_model.mem[36], 32'hA5A5_0001);
    wb(1'b0, REG_INT_STAT, 32'h0);
    chk(q[INT_SUSP], 1'b1);
    wb(1'b1, REG_CTRL, 32'h2 | (32'h1 << CTL_CH_LO));
    wb(1'b1, REG_INT_STAT, 32'hF);
    err_on <= 1'b1;
    ctrl = 16'h0101;
    run(2'h2, 16'h3, 1'b0);
    wb(1'b0, REG_INT_STAT, 32'h0);
    chk(q[INT_ERR], 1'b1);
    chk(i_dbc_mem_model.mem[40][15:0], 16'h0100);
    chk(i_dbc_mem_model.mem[40][31:16], 16'h0003);
    err_on <= 1'b0;
    stall <= 2'h3;
    wb(1'b1, REG_INT_STAT, 32'hF);
    ctrl = 16'h0401;
    run(2'h3, 16'h8, 1'b1);
    chk(st, 3'h0);
    chk(i_dbc_mem_model.mem[44][15:0], 16'h0400);
    summarize();
  end
endmodule
`default_nettype wire
